//--- ipb_pkg.sv
// Constants, field layout and carrier types of the priority bank.
// Assumes a single clock domain and an AXI4-Lite master in front.
package ipb_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;
	localparam int unsigned NUM_REGS = 6;
	localparam int unsigned SLOTS = 4;
	localparam int unsigned FIELD_W = 3;
	localparam int unsigned NUM_SRC = 22;
	localparam int unsigned SLOT_STRIDE = 4;
	localparam int unsigned NUM_LANES = 2;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] PRIO_CTRL_1_OFFS = 8'h00;
	localparam logic [7:0] PRIO_CTRL_2_OFFS = 8'h04;
	localparam logic [7:0] PRIO_CTRL_3_OFFS = 8'h08;
	localparam logic [7:0] PRIO_CTRL_4_OFFS = 8'h0c;
	localparam logic [7:0] PRIO_CTRL_5_OFFS = 8'h10;
	localparam logic [7:0] PRIO_CTRL_6_OFFS = 8'h14;
	localparam logic [7:0] SRC_ENABLE_OFFS = 8'h18;
	localparam logic [7:0] TOP_LEVEL_OFFS = 8'h1c;

	// ------------------------------------------------------------
	// Field positions inside a priority register
	// ------------------------------------------------------------
	localparam int unsigned SLOT3_POS = 12;
	localparam int unsigned SLOT2_POS = 8;
	localparam int unsigned SLOT1_POS = 4;
	localparam int unsigned SLOT0_POS = 0;

	// ------------------------------------------------------------
	// Implemented bits and power-on values, index 0 is register one
	// ------------------------------------------------------------
	localparam logic [NUM_REGS-1:0][REG_W-1:0] IMPL_MASK_TABLE = {
		16'h7777, 16'h7707, 16'h7777, 16'h0777, 16'h7777, 16'h7777
	};
	localparam logic [REG_W-1:0] POR_PATTERN = 16'h4444;

	// ------------------------------------------------------------
	// Priority codes
	// ------------------------------------------------------------
	localparam logic [FIELD_W-1:0] PRIO_DISABLED = 3'h0;
	localparam logic [FIELD_W-1:0] PRIO_LOWEST = 3'h1;
	localparam logic [FIELD_W-1:0] PRIO_HIGHEST = 3'h7;

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {WR_COLLECT, WR_RESPOND} ipb_wr_state_type;

	typedef struct packed {
		logic [2:0] timer2_priority;
		logic [2:0] out_compare2_priority;
		logic [2:0] in_capture2_priority;
		logic [2:0] dma_ch0_done_priority;
		logic [2:0] uart1_receive_priority;
		logic [2:0] spi1_event_priority;
		logic [2:0] spi1_error_priority;
		logic [2:0] timer3_priority;
		logic [2:0] dma_ch1_done_priority;
		logic [2:0] adc1_done_priority;
		logic [2:0] uart1_transmit_priority;
		logic [2:0] change_notify_priority;
		logic [2:0] comparator_priority;
		logic [2:0] i2c1_master_priority;
		logic [2:0] i2c1_slave_priority;
		logic [2:0] in_capture8_priority;
		logic [2:0] in_capture7_priority;
		logic [2:0] ext_irq1_priority;
		logic [2:0] timer4_priority;
		logic [2:0] out_compare4_priority;
		logic [2:0] out_compare3_priority;
		logic [2:0] dma_ch2_done_priority;
	} ipb_levels_type;

endpackage

//--- ipb_prio_reg.sv
// One 16-bit priority register holding four 3-bit fields.
// Assumes the parent drives a one-cycle write pulse with byte strobes.
`timescale 1ns/1ps

module ipb_prio_reg #(
	parameter logic [15:0] IMPL_MASK = 16'hffff
) (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic wr_en_in,
	input wire logic [ipb_pkg::REG_W-1:0] wr_data_in,
	input wire logic [ipb_pkg::NUM_LANES-1:0] wr_strb_in,
	output logic [ipb_pkg::REG_W-1:0] value_out,
	output logic [ipb_pkg::SLOTS-1:0] enable_out
);
	import ipb_pkg::*;

	logic [REG_W-1:0] value_d;
	logic [REG_W-1:0] value_q;
	logic [SLOTS-1:0] enable_d;
	logic [SLOTS-1:0] enable_q;

	// ------------------------------------------------------------
	// Next value
	// ------------------------------------------------------------
	always_comb begin
		value_d = value_q;
		if (wr_en_in) begin
			for (int b = 0; b < NUM_LANES; b++) begin
				if (wr_strb_in[b]) begin
					value_d[8*b +: 8] = wr_data_in[8*b +: 8];
				end
			end
		end
		// Unimplemented bits never hold a one, so reads return zero.
		value_d = value_d & IMPL_MASK;
		for (int s = 0; s < SLOTS; s++) begin
			// Code zero takes the source out of service entirely.
			enable_d[s] = (value_d[SLOT_STRIDE*s +: FIELD_W] !=
				PRIO_DISABLED);
		end
	end

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			value_q <= POR_PATTERN & IMPL_MASK;
		end else begin
			value_q <= value_d;
		end
	end

	// Enables are stored alongside so they need no decode downstream.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			enable_q <= '1;
		end else begin
			enable_q <= enable_d;
		end
	end

	assign value_out = value_q;
	assign enable_out = enable_q;

endmodule // ipb_prio_reg

//--- ipb_bank.sv
// AXI4-Lite slave holding six interrupt priority registers.
// Assumes one clock, a synchronous reset and a well-behaved master.
`timescale 1ns/1ps

module ipb_bank (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [ipb_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic [2:0] s_axi_awprot_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [ipb_pkg::DATA_W-1:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [ipb_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic [2:0] s_axi_arprot_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [ipb_pkg::DATA_W-1:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output ipb_pkg::ipb_levels_type levels_out,
	output logic [ipb_pkg::NUM_SRC-1:0] src_enable_out,
	output logic [ipb_pkg::FIELD_W-1:0] top_level_out
);
	import ipb_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Priority registers occupy consecutive words from offset zero.
	function automatic logic is_prio_reg(input logic [ADDR_W-1:0] a);
		is_prio_reg = (a[ADDR_W-1:2] < (ADDR_W-2)'(NUM_REGS));
	endfunction

	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		reg_index = a[4:2];
	endfunction

	// The code itself is the level, so a plain compare ranks sources.
	function automatic logic [FIELD_W-1:0] max_level(
		input logic [FIELD_W-1:0] a,
		input logic [FIELD_W-1:0] b
	);
		max_level = (a > b) ? a : b;
	endfunction

	// ------------------------------------------------------------
	// Write channel state
	// ------------------------------------------------------------
	ipb_wr_state_type wr_state_q;
	ipb_wr_state_type wr_state_d;
	logic aw_held_q;
	logic aw_held_d;
	logic w_held_q;
	logic w_held_d;
	logic [ADDR_W-1:0] waddr_q;
	logic [REG_W-1:0] wdata_q;
	logic [NUM_LANES-1:0] wstrb_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic aw_take;
	logic w_take;
	logic commit;
	logic [NUM_REGS-1:0] reg_wr_en;

	// ------------------------------------------------------------
	// Read channel state
	// ------------------------------------------------------------
	logic arready_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic ar_take;
	logic [DATA_W-1:0] rd_word;
	logic [1:0] rd_resp;

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	logic [NUM_REGS-1:0][REG_W-1:0] reg_value;
	logic [NUM_REGS-1:0][SLOTS-1:0] reg_enable;
	logic [FIELD_W-1:0] top_level_d;
	logic [FIELD_W-1:0] top_level_q;

	assign aw_take = s_axi_awvalid_in & awready_q;
	assign w_take = s_axi_wvalid_in & wready_q;
	assign ar_take = s_axi_arvalid_in & arready_q;

	// Address and data may arrive in either order; the write is done
	// once both are held, one cycle after the later of the two.
	assign commit = (wr_state_q == WR_COLLECT) & aw_held_q & w_held_q;

	always_comb begin
		wr_state_d = wr_state_q;
		aw_held_d = aw_held_q | aw_take;
		w_held_d = w_held_q | w_take;
		unique case (wr_state_q)
			WR_COLLECT: begin
				if (commit) begin
					wr_state_d = WR_RESPOND;
					aw_held_d = 1'b0;
					w_held_d = 1'b0;
				end
			end
			WR_RESPOND: begin
				if (s_axi_bready_in) begin
					wr_state_d = WR_COLLECT;
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			wr_state_q <= WR_COLLECT;
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end else begin
			wr_state_q <= wr_state_d;
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			awready_q <= ~aw_held_d & (wr_state_d == WR_COLLECT);
			wready_q <= ~w_held_d & (wr_state_d == WR_COLLECT);
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end else begin
			if (aw_take) begin
				waddr_q <= s_axi_awaddr_in;
			end
			if (w_take) begin
				// Only the low two lanes carry register bits.
				wdata_q <= s_axi_wdata_in[REG_W-1:0];
				wstrb_q <= s_axi_wstrb_in[NUM_LANES-1:0];
			end
		end
	end

	// Status words are read-only, so writing them is answered as an error.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (commit) begin
			bvalid_q <= 1'b1;
			bresp_q <= is_prio_reg(waddr_q) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid_q <= 1'b0;
		end
	end

	always_comb begin
		reg_wr_en = '0;
		if (commit && is_prio_reg(waddr_q)) begin
			reg_wr_en[reg_index(waddr_q)] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Priority registers
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		ipb_prio_reg #(
			.IMPL_MASK(IMPL_MASK_TABLE[i])
		) u_reg (
			.clock_in(clock_in),
			.sys_rst_in(sys_rst_in),
			.wr_en_in(reg_wr_en[i]),
			.wr_data_in(wdata_q),
			.wr_strb_in(wstrb_q),
			.value_out(reg_value[i]),
			.enable_out(reg_enable[i])
		);
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rd_word = '0;
		rd_resp = RESP_OKAY;
		if (is_prio_reg(s_axi_araddr_in)) begin
			rd_word[REG_W-1:0] = reg_value[reg_index(s_axi_araddr_in)];
		end else if (s_axi_araddr_in[ADDR_W-1:2] == SRC_ENABLE_OFFS[7:2]) begin
			rd_word[NUM_SRC-1:0] = src_enable_out;
		end else if (s_axi_araddr_in[ADDR_W-1:2] == TOP_LEVEL_OFFS[7:2]) begin
			rd_word[FIELD_W-1:0] = top_level_q;
		end else begin
			rd_resp = RESP_SLVERR;
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_resp;
		end else if (rvalid_q) begin
			if (s_axi_rready_in) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end else begin
			arready_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Highest level in use, a one-cycle lagging summary
	// ------------------------------------------------------------
	always_comb begin
		top_level_d = PRIO_DISABLED;
		for (int r = 0; r < NUM_REGS; r++) begin
			for (int s = 0; s < SLOTS; s++) begin
				top_level_d = max_level(top_level_d,
					reg_value[r][SLOT_STRIDE*s +: FIELD_W]);
			end
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			top_level_q <= PRIO_DISABLED;
		end else begin
			top_level_q <= top_level_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready_out = awready_q;
	assign s_axi_wready_out = wready_q;
	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out = bresp_q;
	assign s_axi_arready_out = arready_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out = rdata_q;
	assign s_axi_rresp_out = rresp_q;
	assign top_level_out = top_level_q;

	// Source order rises with field position, register one first.
	assign src_enable_out = {
		reg_enable[5],
		reg_enable[4][3:2], reg_enable[4][0],
		reg_enable[3],
		reg_enable[2][2:0],
		reg_enable[1],
		reg_enable[0]
	};

	assign levels_out.timer2_priority =
		reg_value[0][SLOT3_POS +: FIELD_W];
	assign levels_out.out_compare2_priority =
		reg_value[0][SLOT2_POS +: FIELD_W];
	assign levels_out.in_capture2_priority =
		reg_value[0][SLOT1_POS +: FIELD_W];
	assign levels_out.dma_ch0_done_priority =
		reg_value[0][SLOT0_POS +: FIELD_W];
	assign levels_out.uart1_receive_priority =
		reg_value[1][SLOT3_POS +: FIELD_W];
	assign levels_out.spi1_event_priority =
		reg_value[1][SLOT2_POS +: FIELD_W];
	assign levels_out.spi1_error_priority =
		reg_value[1][SLOT1_POS +: FIELD_W];
	assign levels_out.timer3_priority =
		reg_value[1][SLOT0_POS +: FIELD_W];
	assign levels_out.dma_ch1_done_priority =
		reg_value[2][SLOT2_POS +: FIELD_W];
	assign levels_out.adc1_done_priority =
		reg_value[2][SLOT1_POS +: FIELD_W];
	assign levels_out.uart1_transmit_priority =
		reg_value[2][SLOT0_POS +: FIELD_W];
	assign levels_out.change_notify_priority =
		reg_value[3][SLOT3_POS +: FIELD_W];
	assign levels_out.comparator_priority =
		reg_value[3][SLOT2_POS +: FIELD_W];
	assign levels_out.i2c1_master_priority =
		reg_value[3][SLOT1_POS +: FIELD_W];
	assign levels_out.i2c1_slave_priority =
		reg_value[3][SLOT0_POS +: FIELD_W];
	assign levels_out.in_capture8_priority =
		reg_value[4][SLOT3_POS +: FIELD_W];
	assign levels_out.in_capture7_priority =
		reg_value[4][SLOT2_POS +: FIELD_W];
	assign levels_out.ext_irq1_priority =
		reg_value[4][SLOT0_POS +: FIELD_W];
	assign levels_out.timer4_priority =
		reg_value[5][SLOT3_POS +: FIELD_W];
	assign levels_out.out_compare4_priority =
		reg_value[5][SLOT2_POS +: FIELD_W];
	assign levels_out.out_compare3_priority =
		reg_value[5][SLOT1_POS +: FIELD_W];
	assign levels_out.dma_ch2_done_priority =
		reg_value[5][SLOT0_POS +: FIELD_W];

endmodule // ipb_bank

//--- ipb_bank_checker.sv
// Assertions on the read answers and level outputs of the priority bank.
// Assumes it is bound to the top module and sees one clock domain.
`timescale 1ns/1ps

module ipb_bank_checker
	import ipb_pkg::*;
(
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic [ipb_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [ipb_pkg::DATA_W-1:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rvalid_out,
	input wire logic s_axi_bvalid_out,
	input wire ipb_pkg::ipb_levels_type levels_out,
	input wire logic [ipb_pkg::NUM_SRC-1:0] src_enable_out,
	input wire logic [ipb_pkg::FIELD_W-1:0] top_level_out
);
	// ----
	// Helper logic
	// ----
	localparam logic [15:0] MASKS [6] = '{16'h7777, 16'h7777, 16'h0777,
		16'h7777, 16'h7707, 16'h7777};
	logic [65:0] lv_c;
	logic [65:0] lv_q;
	logic [7:0] ar_q;
	logic [2:0] max_c;
	assign lv_c = levels_out;

	// Rebuilds a register word from the flat levels, skipping unused slots.
	function automatic logic [15:0] word_of(input logic [65:0] lv, input int k);
		logic [15:0] w;
		int n;
		w = 16'h0000;
		n = 0;
		for (int r = 0; r < 6; r++)
			for (int s = 3; s >= 0; s--)
				if (MASKS[r][4*s]) begin
					if (r == k) w[4*s+:3] = lv[65-3*n-:3];
					n++;
				end
		return w;
	endfunction

	always_comb begin
		max_c = 3'h0;
		for (int j = 0; j < 22; j++)
			if (lv_c[3*j+:3] > max_c) max_c = lv_c[3*j+:3];
	end
	always_ff @(posedge clock_in) begin
		lv_q <= lv_c;
	end
	always_ff @(posedge clock_in) begin
		if (s_axi_arvalid_in && s_axi_arready_out) ar_q <= s_axi_araddr_in;
	end

	// ----
	// Assertions
	// ----
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	top_max_a:
	assert property (!sys_rst_in |=> top_level_out == $past(max_c))
		else $error("Top level is not the highest field code.");
	enable_flag_a:
	assert property (src_enable_out[0] == |levels_out.dma_ch0_done_priority
		&& src_enable_out[18] == |levels_out.dma_ch2_done_priority)
		else $error("Source enable disagrees with its field.");
	all_off_a:
	assert property (src_enable_out == 22'h000000 |=> top_level_out == 3'h0)
		else $error("Top level is set with every source off.");
	reset_four_a:
	assert property ($fell(sys_rst_in) |-> lv_c == {22{3'h4}})
		else $error("Fields are not at level four after reset.");
	levels_quiet_a:
	assert property ($changed(lv_c) |-> $rose(s_axi_bvalid_out))
		else $error("Levels changed without a write answer.");
	read_reg1_a:
	assert property ($rose(s_axi_rvalid_out) && ar_q == PRIO_CTRL_1_OFFS
		|-> s_axi_rdata_out == {16'h0000, word_of(lv_q, 0)})
		else $error("Register one reads back wrong.");
	read_reg2_a:
	assert property ($rose(s_axi_rvalid_out) && ar_q == PRIO_CTRL_2_OFFS
		|-> s_axi_rdata_out == {16'h0000, word_of(lv_q, 1)})
		else $error("Register two reads back wrong.");
	read_reg3_a:
	assert property ($rose(s_axi_rvalid_out) && ar_q == PRIO_CTRL_3_OFFS
		|-> s_axi_rdata_out == {16'h0000, word_of(lv_q, 2)})
		else $error("Register three reads back wrong.");
	read_reg4_a:
	assert property ($rose(s_axi_rvalid_out) && ar_q == PRIO_CTRL_4_OFFS
		|-> s_axi_rdata_out == {16'h0000, word_of(lv_q, 3)})
		else $error("Register four reads back wrong.");
	read_reg5_a:
	assert property ($rose(s_axi_rvalid_out) && ar_q == PRIO_CTRL_5_OFFS
		|-> s_axi_rdata_out == {16'h0000, word_of(lv_q, 4)})
		else $error("Register five reads back wrong.");
	read_reg6_a:
	assert property ($rose(s_axi_rvalid_out) && ar_q == PRIO_CTRL_6_OFFS
		|-> s_axi_rdata_out == {16'h0000, word_of(lv_q, 5)})
		else $error("Register six reads back wrong.");

	cover property (top_level_out == PRIO_HIGHEST);
	cover property (src_enable_out == 22'h000000);
	cover property ($rose(s_axi_rvalid_out) && s_axi_rresp_out == RESP_SLVERR);
endmodule // ipb_bank_checker

//--- tb_ipb_bank.sv
// Self-checking bench for the priority bank over its register bus.
// Assumes the package, the design and the checker are compiled first.
`timescale 1ns/1ps

module tb_ipb_bank;
	import ipb_pkg::*;
	// ----
	// Stimulus and observed signals
	// ----
	localparam logic [15:0] MASKS [6] = '{16'h7777, 16'h7777, 16'h0777,
		16'h7777, 16'h7707, 16'h7777};
	// Distinct codes in every slot so a swapped field shows up.
	localparam logic [15:0] PATS [6] = '{16'h1357, 16'h2461, 16'h7652,
		16'h3715, 16'h6143, 16'h5326};
	logic clock_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	ipb_levels_type levels;
	logic [21:0] src_en;
	logic [2:0] top;
	logic [15:0] shadow [6];
	int errors = 0, total_checks = 0, cycles = 0;

	ipb_bank dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.s_axi_awaddr_in(awaddr), .s_axi_awprot_in(3'h0),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
		.s_axi_arprot_in(3'h0), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .levels_out(levels),
		.src_enable_out(src_en), .top_level_out(top));

	initial begin
		forever #2 clock_in = ~clock_in;
	end
	// A hung handshake would otherwise stall the run forever.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			summarize();
		end
	end

	// ----
	// Shared tasks
	// ----
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [65:0] exp,
		input logic [65:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic do_reset();
		sys_rst_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		@(posedge clock_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clock_in);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock_in);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		rd = rdata;
		resp = rresp;
	endtask
	function automatic logic [65:0] lv_exp();
		logic [65:0] e;
		e = 66'h0;
		for (int r = 0; r < 6; r++)
			for (int s = 3; s >= 0; s--)
				if (MASKS[r][4*s]) e = {e[62:0], shadow[r][4*s+:3]};
		return e;
	endfunction

	// ----
	// Scenarios
	// ----
	task automatic t_defaults();
		for (int k = 0; k < 6; k++) begin
			rd_reg(8'(4*k));
			check("reset word", 16'h4444 & MASKS[k], rd);
			check("read resp", RESP_OKAY, resp);
		end
		check("reset levels", {22{3'h4}}, levels);
		check("reset enables", 22'h3fffff, src_en);
		check("reset top", 3'h4, top);
	endtask
	task automatic t_layout();
		for (int k = 0; k < 6; k++) begin
			wr(8'(4*k), 32'hffffffff, 4'hf);
			check("write resp", RESP_OKAY, resp);
			rd_reg(8'(4*k));
			check("ones word", MASKS[k], rd);
			wr(8'(4*k), {16'hffff, PATS[k]}, 4'hf);
			rd_reg(8'(4*k));
			shadow[k] = PATS[k] & MASKS[k];
			check("pattern word", shadow[k], rd);
		end
		check("levels", lv_exp(), levels);
	endtask
	task automatic t_codes();
		for (int k = 0; k < 6; k++) wr(8'(4*k), 32'h0, 4'hf);
		@(negedge clock_in);
		check("off enables", 22'h0, src_en);
		check("off level", 3'h0, top);
		wr(PRIO_CTRL_6_OFFS, 32'h4, 4'hf);
		for (int c = 1; c < 8; c++) begin
			wr(PRIO_CTRL_1_OFFS, 32'(c), 4'hf);
			@(negedge clock_in);
			check("top level", (c > 4) ? c : 4, top);
			check("enables", 22'h040001, src_en);
		end
		rd_reg(SRC_ENABLE_OFFS);
		check("enable word", 32'h00040001, rd);
		rd_reg(TOP_LEVEL_OFFS);
		check("top word", 32'h7, rd);
		wr(TOP_LEVEL_OFFS, 32'h0, 4'hf);
		check("status bresp", RESP_SLVERR, resp);
		rd_reg(TOP_LEVEL_OFFS);
		check("top kept", 32'h7, rd);
	endtask
	task automatic t_refuse();
		wr(8'h20, 32'h7777, 4'hf);
		check("unmapped bresp", RESP_SLVERR, resp);
		rd_reg(8'h20);
		check("unmapped rresp", RESP_SLVERR, resp);
		check("unmapped data", 32'h0, rd);
		wr(PRIO_CTRL_2_OFFS, 32'hffffffff, 4'hc);
		wr(PRIO_CTRL_2_OFFS, 32'hffffffff, 4'h1);
		rd_reg(PRIO_CTRL_2_OFFS);
		check("lane write", 32'h77, rd);
	endtask

	initial begin
		do_reset();
		t_defaults();
		t_layout();
		t_codes();
		t_refuse();
		do_reset();
		t_defaults();
		summarize();
	end
endmodule // tb_ipb_bank

bind ipb_bank ipb_bank_checker u_checker (.clock_in(clock_in),
	.sys_rst_in(sys_rst_in), .s_axi_araddr_in(s_axi_araddr_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.levels_out(levels_out), .src_enable_out(src_enable_out),
	.top_level_out(top_level_out));
